// *** design/pssfs_top.sv ***
// power module supervisor: share bus, alerts, lamps, fault timers, temperatures
`timescale 1ns/100ps
`include "pssfs_consts.svh"
module pssfs_top #(
   parameter int N_UNITS = 6,
   parameter int FAN_CYC = `PSSFS_FAN_PERSIST_MS * (`PSSFS_CLK_HZ / 1000),
   parameter int OCOT_CYC = `PSSFS_OCOT_PERSIST_MS * (`PSSFS_CLK_HZ / 1000),
   parameter int FUSE_CYC = `PSSFS_FUSE_PERSIST_MS * (`PSSFS_CLK_HZ / 1000),
   parameter int EXPIRY_CYC = `PSSFS_EXPIRY_MS * (`PSSFS_CLK_HZ / 1000),
   parameter int BACKUP_CYC = `PSSFS_BACKUP_MS * (`PSSFS_CLK_HZ / 1000),
   parameter int BLINK_CYC = `PSSFS_BLINK_MS * (`PSSFS_CLK_HZ / 1000)
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // load share line, open drain
   input wire logic load_share_line_i,
   output logic load_share_line_o,
   output logic load_share_line_oe,
   input wire logic [7:0] output_current,
   output logic [8:0] voltage_trim_mv,
   // removal kills, low while seated
   input wire logic module_removal_shutdown_n,
   input wire logic battery_removal_shutdown_n,
   output logic module_presence_output,
   // power state
   input wire logic ac_valid,
   input wire logic main_in_regulation,
   input wire logic backup_mode,
   input wire logic backup_battery_unit_ready,
   output logic main_output_enable,
   output logic aux_output_enable,
   // raw fault conditions
   input wire logic fan_fail,
   input wire logic over_current,
   input wire logic over_temp_protect,
   input wire logic over_voltage,
   input wire logic main_pre_oring_unreg,
   input wire logic ac_fuse_fail,
   input wire logic aux_output_fail,
   input wire logic bbu_converter_fail,
   // shelf units
   input wire logic [N_UNITS-1:0] unit_ok,
   input wire logic [N_UNITS-1:0] battery_protection_event,
   input wire logic [N_UNITS-1:0] battery_discharge_stop_event,
   // open collector alerts
   output logic backup_expiry_alert_o,
   output logic backup_expiry_alert_oe,
   output logic redundancy_lost_alert_o,
   output logic redundancy_lost_alert_oe,
   // temperatures, channel 0 inlet, 1 outlet
   input wire logic [63:0] temperature_readings,
   // lamps
   output logic power_status_green,
   output logic power_status_amber,
   output logic fault_lamp_red
);
   localparam int BIT_CYC = `PSSFS_SHARE_BIT_US * (`PSSFS_CLK_HZ / 1000000);
   localparam int GAP_CYC = `PSSFS_SHARE_GAP_BITS * BIT_CYC;
   // threshold tables as named constants so that one byte can be selected per channel
   localparam logic [63:0] TEMP_RESTART = `PSSFS_TEMP_RESTART;
   localparam logic [63:0] TEMP_WARNING = `PSSFS_TEMP_WARNING;
   localparam logic [63:0] TEMP_SHUTDOWN = `PSSFS_TEMP_SHUTDOWN;

   // refuse timings the logic cannot serve
   if (BACKUP_CYC <= EXPIRY_CYC || BLINK_CYC < 2 || N_UNITS < 1) begin : g_bad
      $error("pssfs_top: bad timing or unit count");
   end

   logic kill_ok; // both kill pins held low by the shelf
   logic enable_q; // outputs allowed, before the kill gate
   logic module_on_q; // software turn on
   logic fw_upgrade_q; // firmware upgrade in progress
   logic aux_latch_q; // latched aux or battery converter fault
   logic fan_q, oc_q, ot_q, fuse_q; // qualified faults
   logic general_fault; // any fault that stops the module
   logic [7:0] temp_warn; // per channel at warning
   logic [7:0] temp_sd_q; // per channel shutdown latch
   logic temp_warning_q; // status bit
   logic [31:0] backup_cnt_q; // cycles spent in backup
   logic expiry_q; // backup expiry alert state
   logic red_lost_q; // redundancy lost state
   logic [31:0] blink_cnt_q; // blink half period counter
   logic blink_q; // blink phase, high is lit
   pssfs_pkg::pssfs_share_state_t sh_state_q; // share frame phase
   logic [15:0] sh_cnt_q; // cycles within bit or gap
   logic [2:0] sh_idx_q; // bit index, msb first
   logic sh_arb_q; // still in arbitration
   logic [7:0] sh_cur_q; // own current frozen for the frame
   logic [7:0] sh_rx_q; // largest current seen on bus
   logic sh_master_q; // won the last frame
   logic [8:0] trim_q; // setpoint raise in mV
   logic wb_req; // new bus request this cycle

   // fault persistence timers
   pssfs_persist #(.CYCLES(FAN_CYC)) u_fan (.clock(clock), .rst(rst), .cond(fan_fail), .qualified(fan_q));
   pssfs_persist #(.CYCLES(OCOT_CYC)) u_oc (.clock(clock), .rst(rst), .cond(over_current), .qualified(oc_q));
   pssfs_persist #(.CYCLES(OCOT_CYC)) u_ot (.clock(clock), .rst(rst), .cond(over_temp_protect), .qualified(ot_q));
   pssfs_persist #(.CYCLES(FUSE_CYC)) u_fuse (.clock(clock), .rst(rst), .cond(ac_fuse_fail), .qualified(fuse_q));

   // faults that stop the module
   assign general_fault = fan_q | oc_q | ot_q | fuse_q | over_voltage | main_pre_oring_unreg;

   // per channel compare, with hysteresis on the shutdown latch only
   for (genvar ch = 0; ch < 8; ch++) begin : g_temp
      pssfs_pkg::pssfs_temp_t rd;
      assign rd = temperature_readings[ch*8 +: 8];
      assign temp_warn[ch] = rd >= TEMP_WARNING[ch*8 +: 8];
      // set above shutdown, clear at or below restart; set wins
      always_ff @(posedge clock or posedge rst)
      begin
         if (rst)
            temp_sd_q[ch] <= 1'b0;
         else if (rd > TEMP_SHUTDOWN[ch*8 +: 8])
            temp_sd_q[ch] <= 1'b1;
         else if (rd <= TEMP_RESTART[ch*8 +: 8])
            temp_sd_q[ch] <= 1'b0;
      end
   end

   // warning status bit
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         temp_warning_q <= 1'b0;
      else
         temp_warning_q <= |temp_warn;
   end

   // removal kill acts without a clock edge
   assign kill_ok = !module_removal_shutdown_n && !battery_removal_shutdown_n;
   assign main_output_enable = enable_q & kill_ok;
   assign aux_output_enable = enable_q & kill_ok;
   // presence pin is tied low inside the module
   assign module_presence_output = 1'b0;

   // output enable decision
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         enable_q <= 1'b0;
      else
         enable_q <= module_on_q & kill_ok & ~(|temp_sd_q) & ~general_fault;
   end

   // aux or battery converter failure latch; set wins over clear
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         aux_latch_q <= 1'b0;
      else if (aux_output_fail | bbu_converter_fail)
         aux_latch_q <= 1'b1;
      else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PSSFS_REG_CTRL && wb_dat_i[`PSSFS_CTRL_CLR])
         aux_latch_q <= 1'b0;
   end

   // backup time counter and expiry alert
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         backup_cnt_q <= 32'h00000000;
         expiry_q <= 1'b0;
      end
      else if (!backup_mode)
      begin
         backup_cnt_q <= 32'h00000000;
         expiry_q <= 1'b0;
      end
      else
      begin
         if (backup_cnt_q != 32'(BACKUP_CYC))
            backup_cnt_q <= backup_cnt_q + 32'h00000001;
         expiry_q <= backup_cnt_q >= 32'(EXPIRY_CYC);
      end
   end
   assign backup_expiry_alert_o = 1'b0;
   assign backup_expiry_alert_oe = expiry_q;

   // redundancy lost, battery protect or stop alone excluded
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         red_lost_q <= 1'b0;
      else
         red_lost_q <= |(~unit_ok & ~(battery_protection_event | battery_discharge_stop_event));
   end
   assign redundancy_lost_alert_o = 1'b0;
   assign redundancy_lost_alert_oe = red_lost_q;

   // blink phase generator
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         blink_cnt_q <= 32'h00000000;
         blink_q <= 1'b0;
      end
      else if (blink_cnt_q == 32'(BLINK_CYC - 1))
      begin
         blink_cnt_q <= 32'h00000000;
         blink_q <= ~blink_q;
      end
      else
      begin
         blink_cnt_q <= blink_cnt_q + 32'h00000001;
      end
   end

   // power status lamp, in priority order
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         power_status_green <= 1'b0;
         power_status_amber <= 1'b0;
      end
      else if (!main_output_enable || !main_in_regulation)
      begin
         power_status_green <= 1'b0;
         power_status_amber <= 1'b0;
      end
      else if (fw_upgrade_q)
      begin
         power_status_green <= blink_q;
         power_status_amber <= 1'b0;
      end
      else if (backup_mode)
      begin
         power_status_green <= 1'b0;
         power_status_amber <= blink_q && backup_cnt_q != 32'(BACKUP_CYC);
      end
      else if (ac_valid)
      begin
         power_status_green <= backup_battery_unit_ready;
         power_status_amber <= ~backup_battery_unit_ready;
      end
      else
      begin
         power_status_green <= 1'b0;
         power_status_amber <= 1'b0;
      end
   end

   // red lamp: faults, latched converter fault, temperature
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         fault_lamp_red <= 1'b0;
      else
         fault_lamp_red <= general_fault | aux_latch_q | temp_warning_q | (|temp_sd_q);
   end

   // share bus frame: start bit then eight bits msb first
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sh_state_q <= pssfs_pkg::SH_IDLE;
         sh_cnt_q <= 16'h0000;
         sh_idx_q <= 3'h7;
         sh_arb_q <= 1'b0;
         sh_cur_q <= 8'h00;
         sh_rx_q <= 8'h00;
      end
      else if (!main_output_enable)
      begin
         sh_state_q <= pssfs_pkg::SH_IDLE;
         sh_cnt_q <= 16'h0000;
         sh_arb_q <= 1'b0;
      end
      else
      begin
         unique case (sh_state_q)
            pssfs_pkg::SH_IDLE:
            begin
               // join a peer start or open a frame after the gap
               if (!load_share_line_i || sh_cnt_q == 16'(GAP_CYC - 1))
               begin
                  sh_state_q <= pssfs_pkg::SH_START;
                  sh_cnt_q <= 16'h0000;
                  sh_cur_q <= output_current;
               end
               else
                  sh_cnt_q <= sh_cnt_q + 16'h0001;
            end
            pssfs_pkg::SH_START:
            begin
               if (sh_cnt_q == 16'(BIT_CYC - 1))
               begin
                  sh_state_q <= pssfs_pkg::SH_BITS;
                  sh_cnt_q <= 16'h0000;
                  sh_idx_q <= 3'h7;
                  sh_arb_q <= 1'b1;
               end
               else
                  sh_cnt_q <= sh_cnt_q + 16'h0001;
            end
            pssfs_pkg::SH_BITS:
            begin
               // sample mid bit: low line is a one
               if (sh_cnt_q == 16'(BIT_CYC / 2))
               begin
                  sh_rx_q[sh_idx_q] <= ~load_share_line_i;
                  if (!sh_cur_q[sh_idx_q] && !load_share_line_i)
                     sh_arb_q <= 1'b0;
               end
               if (sh_cnt_q == 16'(BIT_CYC - 1))
               begin
                  sh_cnt_q <= 16'h0000;
                  sh_idx_q <= sh_idx_q - 3'h1;
                  if (sh_idx_q == 3'h0)
                     sh_state_q <= pssfs_pkg::SH_IDLE;
               end
               else
                  sh_cnt_q <= sh_cnt_q + 16'h0001;
            end
         endcase
      end
   end

   // line driven low only for start and for own one bits
   assign load_share_line_o = 1'b0;
   assign load_share_line_oe = main_output_enable && (sh_state_q == pssfs_pkg::SH_START ||
      (sh_state_q == pssfs_pkg::SH_BITS && sh_arb_q && sh_cur_q[sh_idx_q]));

   // master flag and slave trim at frame end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sh_master_q <= 1'b0;
         trim_q <= 9'h000;
      end
      else if (!main_output_enable)
      begin
         sh_master_q <= 1'b0;
         trim_q <= 9'h000;
      end
      else if (sh_state_q == pssfs_pkg::SH_BITS && sh_idx_q == 3'h0 && sh_cnt_q == 16'(BIT_CYC - 1))
      begin
         sh_master_q <= sh_arb_q;
         if (sh_arb_q)
            trim_q <= 9'h000;
         else if ({1'b0, sh_cur_q} + {1'b0, `PSSFS_SHARE_MARGIN} < {1'b0, sh_rx_q})
            trim_q <= (trim_q > `PSSFS_TRIM_MAX_MV - `PSSFS_TRIM_STEP_MV) ? `PSSFS_TRIM_MAX_MV
               : trim_q + `PSSFS_TRIM_STEP_MV;
         else if (sh_cur_q >= sh_rx_q)
            trim_q <= (trim_q < `PSSFS_TRIM_STEP_MV) ? 9'h000 : trim_q - `PSSFS_TRIM_STEP_MV;
      end
   end
   assign voltage_trim_mv = trim_q;

   // wishbone slave: answers only, never initiates
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req && !wb_we_i)
         begin
            unique case (wb_adr_i)
               `PSSFS_REG_CTRL: wb_dat_o <= {30'h00000000, fw_upgrade_q, module_on_q};
               `PSSFS_REG_STATUS: wb_dat_o <= {21'h000000, fault_lamp_red, power_status_amber,
                  power_status_green, general_fault, aux_latch_q, |temp_sd_q, temp_warning_q,
                  red_lost_q, expiry_q, sh_master_q, main_output_enable};
               `PSSFS_REG_SHARE: wb_dat_o <= {8'h00, sh_rx_q, 7'h00, trim_q};
               `PSSFS_REG_TEMP: wb_dat_o <= {16'h0000, temp_sd_q, temp_warn};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   // control register write
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         module_on_q <= 1'b0;
         fw_upgrade_q <= 1'b0;
      end
      else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `PSSFS_REG_CTRL)
      begin
         module_on_q <= wb_dat_i[`PSSFS_CTRL_ON];
         fw_upgrade_q <= wb_dat_i[`PSSFS_CTRL_FWUP];
      end
   end

   // checks on the block's own outputs
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_frame_open;
      sh_state_q == pssfs_pkg::SH_IDLE ##1 sh_state_q == pssfs_pkg::SH_START;
   endsequence
   property p_share_release;
      (!module_on_q || general_fault) |=> !load_share_line_oe;
   endproperty
   a_share_release: assert property (p_share_release) else $error("share line held while off");
   property p_frame_start;
      s_frame_open ##0 main_output_enable ##1 main_output_enable |-> load_share_line_oe && $past(load_share_line_oe);
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("start bit not driven");
   property p_trim_limit;
      trim_q <= `PSSFS_TRIM_MAX_MV && (sh_master_q -> trim_q == 9'h000);
   endproperty
   a_trim_limit: assert property (p_trim_limit) else $error("trim beyond limit");
   property p_kill;
      module_removal_shutdown_n || battery_removal_shutdown_n |-> !main_output_enable && !aux_output_enable;
   endproperty
   a_kill: assert property (p_kill) else $error("outputs on during removal");
   property p_expiry;
      backup_mode && $past(backup_mode) && backup_cnt_q > 32'(EXPIRY_CYC) |-> backup_expiry_alert_oe;
   endproperty
   a_expiry: assert property (p_expiry) else $error("expiry alert missing");
   property p_red_lost;
      (&unit_ok) |=> !redundancy_lost_alert_oe;
   endproperty
   a_red_lost: assert property (p_red_lost) else $error("redundancy alert with all healthy");
   property p_lamp_dark;
      !main_in_regulation |=> !power_status_green && !power_status_amber;
   endproperty
   a_lamp_dark: assert property (p_lamp_dark) else $error("power lamp lit out of regulation");
   property p_temp_sd;
      (|temp_sd_q) |=> !main_output_enable && fault_lamp_red;
   endproperty
   a_temp_sd: assert property (p_temp_sd) else $error("outputs on over temperature");
   property p_answer_only;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_answer_only: assert property (p_answer_only) else $error("ack without a request");
endmodule : pssfs_top

// *** design/pssfs_consts.svh ***
// constants of the power module status and fault supervisor
`ifndef PSSFS_CONSTS_SVH
`define PSSFS_CONSTS_SVH

// clock rate and time figures
`define PSSFS_CLK_HZ 20000000
`define PSSFS_FAN_PERSIST_MS 5000
`define PSSFS_OCOT_PERSIST_MS 2000
`define PSSFS_FUSE_PERSIST_MS 5000
`define PSSFS_EXPIRY_MS 45000
`define PSSFS_BACKUP_MS 90000
`define PSSFS_BLINK_MS 500
`define PSSFS_SHARE_BIT_US 10
`define PSSFS_SHARE_GAP_BITS 4

// share trim figures in millivolts, margin in output current units
`define PSSFS_TRIM_MAX_MV 9'h0FA
`define PSSFS_TRIM_STEP_MV 9'h00A
`define PSSFS_SHARE_MARGIN 8'h02

// per channel thresholds in degC, channel 7 in the top byte
`define PSSFS_TEMP_RESTART 64'h6E5F6E6E5F646432
`define PSSFS_TEMP_WARNING 64'h7364737364696937
`define PSSFS_TEMP_SHUTDOWN 64'h78697878696E6E3C

// register byte offsets
`define PSSFS_REG_CTRL 8'h00
`define PSSFS_REG_STATUS 8'h04
`define PSSFS_REG_SHARE 8'h08
`define PSSFS_REG_TEMP 8'h0C

// control register fields
`define PSSFS_CTRL_ON 0
`define PSSFS_CTRL_FWUP 1
`define PSSFS_CTRL_CLR 2

`endif

// *** design/pssfs_pkg.sv ***
// types of the power module status and fault supervisor
package pssfs_pkg;
   // load share bus frame phases
   typedef enum logic [1:0] {SH_IDLE, SH_START, SH_BITS} pssfs_share_state_t;
   // one temperature reading in degC
   typedef logic [7:0] pssfs_temp_t;
endpackage : pssfs_pkg

// *** design/pssfs_persist.sv ***
// persistence qualifier: a condition must hold for a number of cycles
`timescale 1ns/100ps
module pssfs_persist #(
   parameter int CYCLES = 16
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // raw condition and qualified result
   input wire logic cond,
   output logic qualified
);
   localparam int CW = $clog2(CYCLES + 1);

   // refuse a count the counter cannot serve
   if (CYCLES < 1) begin : g_bad
      $error("pssfs_persist: CYCLES below one");
   end

   logic [CW-1:0] cnt_q; // cycles of continuous condition

   // count while the condition stands, restart on any gap
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= '0;
         qualified <= 1'b0;
      end
      else if (!cond)
      begin
         cnt_q <= '0;
         qualified <= 1'b0;
      end
      else if (cnt_q != CW'(CYCLES - 1))
      begin
         cnt_q <= cnt_q + 1'b1;
      end
      else
      begin
         qualified <= 1'b1;
      end
   end

   // a gap always drops the qualified flag
   property p_gap_clears;
      @(posedge clock) disable iff (rst) !cond |=> !qualified;
   endproperty
   a_gap_clears: assert property (p_gap_clears) else $error("qualified flag survived a gap");
endmodule : pssfs_persist

// *** verification/pssfs_peer.sv ***
// peer power module on the recessive load share bus
`timescale 1ns/100ps
module pssfs_peer #(
   parameter int BIT_CYC = 200
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // bus level, own current and state, own pull-down
   input wire logic line,
   input wire logic [7:0] cur,
   input wire logic on,
   output logic pull
);
   int idx_q; // 0 start, 1..8 data msb first, 9 idle
   int cnt_q; // cycle within a bit
   logic lost_q; // dropped out of arbitration
   // follows every frame start, drops out when beaten
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         idx_q <= 9;
         cnt_q <= 0;
         lost_q <= 1'b0;
      end
      else if (idx_q == 9)
      begin
         lost_q <= !on;
         idx_q <= line ? 9 : 0;
         cnt_q <= 0;
      end
      else
      begin
         cnt_q <= (cnt_q == BIT_CYC - 1) ? 0 : cnt_q + 1;
         idx_q <= (cnt_q == BIT_CYC - 1) ? idx_q + 1 : idx_q;
         if (idx_q > 0 && cnt_q == BIT_CYC / 2 && !cur[8 - idx_q] && !line)
         begin
            lost_q <= 1'b1;
         end
      end
   end
   // only ever pulls low, the bus idles high
   assign pull = idx_q < 9 && !lost_q && (idx_q == 0 || cur[8 - idx_q]);
endmodule : pssfs_peer

// *** verification/tb_top.sv ***
// self-checking bench of the supervisor with one peer on the share bus
`timescale 1ns/100ps
`include "pssfs_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   localparam int P = 20; // shortened persistence
   logic clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, output_current, peer_cur;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, r;
   logic load_share_line_i, load_share_line_o, load_share_line_oe, peer_pull, peer_on;
   logic [8:0] voltage_trim_mv;
   logic module_removal_shutdown_n, battery_removal_shutdown_n, module_presence_output;
   logic ac_valid, main_in_regulation, backup_mode, backup_battery_unit_ready;
   logic main_output_enable, aux_output_enable, aux_output_fail, bbu_converter_fail;
   logic fan_fail, over_current, over_temp_protect, over_voltage, main_pre_oring_unreg, ac_fuse_fail;
   logic [5:0] fv, unit_ok, battery_protection_event, battery_discharge_stop_event;
   logic backup_expiry_alert_o, backup_expiry_alert_oe, redundancy_lost_alert_o, redundancy_lost_alert_oe;
   logic [63:0] temperature_readings, rs, ws, ss;
   logic power_status_green, power_status_amber, fault_lamp_red;
   logic [2:0] s;
   int fail_count, check_count, n, k;
   wire [1:0] lamp = {power_status_green, power_status_amber};
   // raw faults, persistent ones in the low four bits
   assign {main_pre_oring_unreg, over_voltage, ac_fuse_fail, over_temp_protect, over_current, fan_fail} = fv;
   // pulled-up share bus, any party pulling wins
   assign load_share_line_i = !(peer_pull || (load_share_line_oe && !load_share_line_o));
   pssfs_top #(.FAN_CYC(P), .OCOT_CYC(P), .FUSE_CYC(P), .EXPIRY_CYC(50), .BACKUP_CYC(100), .BLINK_CYC(4)) i_dut (.*);
   pssfs_peer i_peer (.clock, .rst, .line(load_share_line_i), .cur(peer_cur), .on(peer_on), .pull(peer_pull));
   // 20 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = !clock;
   end
   task tick(input int c);
      repeat (c) @(posedge clock);
   endtask : tick
   task complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run
   // one classic cycle, read data left in r
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (wb_ack_o !== 1'b1 && k < 20);
      if (wb_ack_o !== 1'b1)
      begin
         fail_count++;
         complete_run();
      end
      r = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask : wb
   // all inputs to idle values, then reset for four cycles
   task do_reset();
      rst <= 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {11'h000, 4'hF, 32'h0};
      {output_current, peer_cur, peer_on, module_removal_shutdown_n, battery_removal_shutdown_n} <= 19'h0;
      {ac_valid, main_in_regulation, backup_mode, backup_battery_unit_ready, fv, aux_output_fail,
         bbu_converter_fail} <= 12'hD00;
      {unit_ok, battery_protection_event, battery_discharge_stop_event} <= 18'h3F000;
      temperature_readings <= {8{8'h14}};
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
   endtask : do_reset
   task start();
      do_reset();
      wb(1'b1, 8'h00, 32'h1);
      tick(4);
   endtask : start
   task temp(input int c, input logic [7:0] v);
      temperature_readings[c*8+:8] <= v;
      tick(5);
   endtask : temp
   // lamp must alternate between col and dark only
   task blink(input logic [1:0] col);
      s = 3'h0;
      repeat (12)
      begin
         @(negedge clock);
         s = s | {lamp != col && lamp != 2'h0, lamp == 2'h0, lamp == col};
      end
      `CHK(s, 3'h3)
      @(posedge clock);
   endtask : blink
   function automatic logic red_exp(input logic [5:0] ok, input logic [5:0] p, input logic [5:0] d);
      return |(~ok & ~p & ~d);
   endfunction : red_exp
   // main sequence
   initial
   begin
      fail_count = 0;
      check_count = 0;
      void'($urandom(32'h42AD));
      do_reset();
      `CHK({load_share_line_oe, backup_expiry_alert_oe, redundancy_lost_alert_oe, main_output_enable}, 4'h0)
      `CHK({module_presence_output, load_share_line_o, redundancy_lost_alert_o}, 3'h0)
      `CHK({lamp, fault_lamp_red}, 3'h0)
      wb(1'b0, 8'h40, 32'h0);
      `CHK(r, 32'h0)
      wb(1'b1, 8'h00, 32'h1);
      tick(4);
      `CHK({main_output_enable, lamp}, 3'h6)
      backup_battery_unit_ready <= 1'b0;
      tick(3);
      `CHK(lamp, 2'h1)
      main_in_regulation <= 1'b0;
      tick(3);
      `CHK(lamp, 2'h0)
      {main_in_regulation, backup_battery_unit_ready} <= 2'h3;
      wb(1'b1, 8'h00, 32'h3);
      blink(2'h2);
      wb(1'b1, 8'h00, 32'h1);
      {backup_mode, ac_valid} <= 2'h2;
      tick(2);
      blink(2'h1);
      tick(28);
      `CHK(backup_expiry_alert_oe, 1'b0)
      tick(16);
      `CHK({backup_expiry_alert_oe, backup_expiry_alert_o}, 2'h2)
      tick(50);
      `CHK(lamp, 2'h0)
      {backup_mode, ac_valid} <= 2'h1;
      for (int i = 0; i < 24; i++)
      begin
         unit_ok <= (i == 0) ? 6'h3E : 6'($urandom);
         battery_protection_event <= (i == 0) ? 6'h01 : 6'($urandom);
         battery_discharge_stop_event <= 6'($urandom);
         tick(3);
         `CHK(redundancy_lost_alert_oe, red_exp(unit_ok, battery_protection_event, battery_discharge_stop_event))
      end
      for (int i = 0; i < 2; i++)
      begin
         {module_removal_shutdown_n, battery_removal_shutdown_n} <= i ? 2'h1 : 2'h2;
         @(negedge clock);
         `CHK({main_output_enable, aux_output_enable}, 2'h0)
         @(posedge clock);
         {module_removal_shutdown_n, battery_removal_shutdown_n} <= 2'h0;
      end
      for (int i = 0; i < 6; i++)
      begin
         start();
         fv <= 6'h01 << i;
         if (i < 4)
         begin
            tick(P - 3);
            `CHK(fault_lamp_red, 1'b0)
         end
         tick(8);
         `CHK({fault_lamp_red, main_output_enable}, 2'h2)
      end
      for (int i = 0; i < 2; i++)
      begin
         start();
         {aux_output_fail, bbu_converter_fail} <= i ? 2'h1 : 2'h2;
         tick(1);
         {aux_output_fail, bbu_converter_fail} <= 2'h0;
         tick(6);
         `CHK({fault_lamp_red, main_output_enable}, 2'h3)
         wb(1'b1, 8'h00, 32'h5);
         tick(3);
         `CHK(fault_lamp_red, 1'b0)
      end
      start();
      rs = `PSSFS_TEMP_RESTART;
      ws = `PSSFS_TEMP_WARNING;
      ss = `PSSFS_TEMP_SHUTDOWN;
      {rs[15:0], ws[15:0], ss[15:0]} = 48'h6432_6937_6E3C;
      for (int c = 0; c < 8; c++)
      begin
         temp(c, ws[c*8+:8] - 8'h01);
         wb(1'b0, 8'h0C, 32'h0);
         `CHK(r[c], 1'b0)
         temp(c, ws[c*8+:8]);
         wb(1'b0, 8'h04, 32'h0);
         `CHK({r[4], fault_lamp_red}, 2'h3)
         temp(c, ss[c*8+:8]);
         `CHK(main_output_enable, 1'b1)
         temp(c, ss[c*8+:8] + 8'h01);
         `CHK(main_output_enable, 1'b0)
         temp(c, rs[c*8+:8] + 8'h01);
         `CHK(main_output_enable, 1'b0)
         temp(c, rs[c*8+:8]);
         `CHK(main_output_enable, 1'b1)
         temp(c, 8'h14);
      end
      {output_current, peer_cur, peer_on} <= {8'($urandom_range(100)), 8'hC8, 1'b1};
      for (int i = 0; i < 29; i++)
      begin
         tick(2600);
         `CHK(voltage_trim_mv > 9'h0FA, 1'b0)
      end
      `CHK(voltage_trim_mv, 9'h0FA)
      output_current <= 8'hFF;
      tick(6000);
      wb(1'b0, 8'h04, 32'h0);
      `CHK({r[1], voltage_trim_mv}, 10'h200)
      wb(1'b1, 8'h00, 32'h0);
      n = 0;
      repeat (3000)
      begin
         @(posedge clock);
         n += int'(load_share_line_oe !== 1'b0);
      end
      `CHK(n, 0)
      `CHK(voltage_trim_mv, 9'h000)
      complete_run();
   end
endmodule : tb_top
